// *** mcsr_pkg.sv ***
// package for the master control and status register bank
// assumes a classic wishbone slave with 8-bit registers on 32-bit aligned words
package mcsr_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] MCSR_IDX_RESET = 8'h00; // soft reset, revision, meter load
  localparam logic [7:0] MCSR_IDX_CFG = 8'h01; // master configuration
  localparam logic [7:0] MCSR_IDX_IRQ = 8'h02; // block interrupt summary
  localparam logic [7:0] MCSR_IDX_RATE = 8'h03; // line rate select
  localparam logic [7:0] MCSR_IDX_CLK = 8'h04; // clock activity monitor
  localparam int MCSR_TEST_SEL_BIT = 7; // index bit selecting test registers
  // ==========================================================
  // field positions
  localparam int MCSR_RESET_BIT = 7;
  localparam int MCSR_TIP_BIT = 3;
  localparam int MCSR_FP_IN_BIT = 0;
  localparam int MCSR_RSVD_BIT = 1;
  localparam int MCSR_RXPOL_BIT = 2;
  localparam int MCSR_TXPOL_BIT = 3;
  localparam int MCSR_APRDI_BIT = 4;
  localparam int MCSR_ALRDI_BIT = 5;
  localparam int MCSR_AFEBE_BIT = 6;
  localparam int MCSR_LCD_BIT = 6;
  // ==========================================================
  // reset values
  localparam logic [6:0] MCSR_CFG_RST = 7'h71; // febe, lrdi, prdi, frame pulse in
  localparam logic [1:0] MCSR_RATE_RST = 2'h3; // 155.52 mbit/s
  localparam logic [1:0] MCSR_RATE_STS1 = 2'h2; // 51.84 mbit/s
  // identity fields: arbitrary neutral values
  localparam logic [2:0] MCSR_FAMILY_CODE = 3'h5; // arbitrary value
  localparam logic [2:0] MCSR_REVISION = 3'h2; // arbitrary value
  // ==========================================================
  // meter transfer length in sys_clk cycles
  localparam logic [3:0] MCSR_XFER_CYCLES = 4'h8;
  localparam int MCSR_NCLK = 5; // monitored clocks
  typedef enum logic [1:0] {
    MCSR_IDLE = 2'b00,
    MCSR_XFER = 2'b01,
    MCSR_DONE = 2'b11
  } mcsr_xfer_e;
endpackage

// *** mcsr_top.sv ***
// master control and status register bank of an atm line interface
// assumes a classic wishbone master on sys_clk and monitored clocks sampled as data
`timescale 1ns/10ps
`default_nettype none
module mcsr_top
  import mcsr_pkg::*;
(
  input wire logic sys_clk, // 50 mhz system clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic clk_en, // freezes all state while low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [9:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic soft_reset_o, // whole-device reset and standby request
  output logic meter_load_o, // one-cycle pulse latching all meters
  input wire logic meter_busy_i, // meter blocks still transferring
  input wire logic fp_i, // frame pulse pin input level
  output logic fp_o, // frame pulse pin output level
  output logic fp_oe, // frame pulse pin drive enable
  input wire logic tx_frame_pulse_i, // internal transmit overhead frame pulse
  output logic fp_align_o, // reference pulse for frame alignment
  input wire logic rx_cell_avail_i, // raw receive cell available
  output logic receive_cell_avail, // receive cell available, set polarity
  input wire logic tx_cell_avail_i, // raw transmit fifo space
  output logic transmit_cell_avail, // transmit cell available, set polarity
  input wire logic los_i, // loss of signal declared
  input wire logic lof_i, // loss of frame declared
  input wire logic line_ais_i, // line ais declared
  input wire logic lop_i, // loss of pointer declared
  input wire logic path_ais_i, // path ais declared
  output logic path_rdi_o, // insert path rdi
  output logic line_rdi_o, // insert line rdi
  input wire logic line_bip_err_i, // one-cycle line bip error event
  input wire logic path_bip_err_i, // one-cycle path bip error event
  output logic line_febe_o, // one-cycle line febe insert
  output logic path_febe_o, // one-cycle path febe insert
  input wire logic [7:0] block_irq_i, // block requests, bit 6 unused
  input wire logic lcd_state_i, // loss of cell delineation state
  input wire logic cell_delin_irq_enable, // delineation interrupt enable
  input wire logic [mcsr_pkg::MCSR_NCLK-1:0] mon_clk_i, // monitored clocks as data
  output logic [1:0] line_rate_o, // selected line rate code
  output logic irq_out_n // interrupt, active low
);
  import mcsr_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic ack; // bus answer
    logic [31:0] rdat; // read data
    logic srst; // soft reset bit
    logic [6:0] cfg; // master configuration bits
    logic [1:0] rate; // line rate code
    logic cell_delin_irq; // delineation change flag
    logic lcd_prev; // last delineation state
    logic [MCSR_NCLK-1:0] act; // activity bits
    logic [MCSR_NCLK-1:0] clk_prev; // last monitored clock levels
    mcsr_xfer_e xst; // meter transfer state
    logic [3:0] xcnt; // transfer cycle count
    logic load; // meter load pulse
    logic lfebe; // line febe pulse
    logic pfebe; // path febe pulse
    logic fpo; // registered frame pulse out
  } mcsr_state_s;

  mcsr_state_s state_q, state_d;
  logic req; // new access this cycle
  logic hit; // access inside normal mode map
  logic [7:0] idx; // register index
  logic [7:0] summary; // interrupt summary view
  logic transfer_in_progress; // transfer in progress

  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i && wb_stb_i && !state_q.ack;
  assign hit = !idx[MCSR_TEST_SEL_BIT];
  assign transfer_in_progress = (state_q.xst != MCSR_IDLE);

  // block requests straight through; delineation bit is the sticky flag
  always_comb begin
    summary = block_irq_i;
    summary[MCSR_LCD_BIT] = state_q.cell_delin_irq;
  end

  // ==========================================================
  // next-state logic
  always_comb begin
    logic rd; // read access taken
    logic wr; // write access taken
    rd = 1'b0;
    wr = 1'b0;
    state_d = state_q;
    state_d.ack = 1'b0;
    state_d.load = 1'b0;
    // one febe per bip event, none when disabled
    state_d.lfebe = state_q.cfg[MCSR_AFEBE_BIT] && line_bip_err_i;
    state_d.pfebe = state_q.cfg[MCSR_AFEBE_BIT] && path_bip_err_i;
    state_d.fpo = tx_frame_pulse_i;
    if (req) begin
      // always answer, unmapped reads give zero
      state_d.ack = 1'b1;
      state_d.rdat = 32'h0;
      rd = hit && !wb_we_i;
      wr = hit && wb_we_i && wb_sel_i[0];
      if (rd) begin
        case (idx)
          MCSR_IDX_RESET: begin
            state_d.rdat[7:0] = {state_q.srst, MCSR_FAMILY_CODE, transfer_in_progress, MCSR_REVISION};
          end
          MCSR_IDX_CFG: begin
            state_d.rdat[6:0] = state_q.cfg;
          end
          MCSR_IDX_IRQ: begin
            state_d.rdat[7:0] = summary;
          end
          MCSR_IDX_RATE: begin
            state_d.rdat[1:0] = state_q.rate;
          end
          MCSR_IDX_CLK: begin
            state_d.rdat[MCSR_NCLK-1:0] = state_q.act;
          end
          default: begin
            state_d.rdat = 32'h0;
          end
        endcase
      end
      if (wr) begin
        case (idx)
          MCSR_IDX_RESET: begin
            state_d.srst = wb_dat_i[MCSR_RESET_BIT];
            if (!wb_dat_i[MCSR_RESET_BIT]) begin
              state_d.load = 1'b1;
              state_d.xst = MCSR_XFER;
              state_d.xcnt = 4'h0;
            end
          end
          MCSR_IDX_CFG: begin
            state_d.cfg = wb_dat_i[6:0];
          end
          MCSR_IDX_RATE: begin
            state_d.rate = wb_dat_i[1:0];
          end
          default: begin
            state_d.rate = state_d.rate; // read-only and unused words ignore writes
          end
        endcase
      end
    end
    // meter transfer: fixed minimum then wait for meters to settle
    if (!(wr && idx == MCSR_IDX_RESET)) begin
      case (state_q.xst)
        MCSR_IDLE: begin
          state_d.xcnt = 4'h0;
        end
        MCSR_XFER: begin
          state_d.xcnt = state_q.xcnt + 4'h1;
          if (state_q.xcnt == MCSR_XFER_CYCLES - 4'h1) begin
            state_d.xst = MCSR_DONE;
          end
        end
        MCSR_DONE: begin
          if (!meter_busy_i) begin
            state_d.xst = MCSR_IDLE;
          end
        end
        default: begin
          state_d.xst = MCSR_IDLE;
        end
      endcase
    end
    // delineation change flag: set wins over read-clear
    state_d.lcd_prev = lcd_state_i;
    if (rd && idx == MCSR_IDX_IRQ) begin
      state_d.cell_delin_irq = 1'b0;
    end
    if (lcd_state_i != state_q.lcd_prev) begin
      state_d.cell_delin_irq = 1'b1;
    end
    // clock activity: read clears all, a new edge wins
    state_d.clk_prev = mon_clk_i;
    if (rd && idx == MCSR_IDX_CLK) begin
      state_d.act = '0;
    end
    for (int i = 0; i < MCSR_NCLK; i++) begin
      if (mon_clk_i[i] && !state_q.clk_prev[i]) begin
        state_d.act[i] = 1'b1;
      end
    end
  end

  // ==========================================================
  // state register; hardware reset also clears the soft reset bit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= '0;
      state_q.cfg <= MCSR_CFG_RST;
      state_q.rate <= MCSR_RATE_RST;
      state_q.xst <= MCSR_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // outputs
  assign wb_ack_o = state_q.ack;
  assign wb_dat_o = state_q.rdat;
  assign soft_reset_o = state_q.srst;
  assign meter_load_o = state_q.load;
  assign line_rate_o = state_q.rate;
  // pin drives out only when not selected as input
  assign fp_oe = !state_q.cfg[MCSR_FP_IN_BIT];
  assign fp_o = state_q.fpo;
  assign fp_align_o = state_q.cfg[MCSR_FP_IN_BIT] && fp_i;
  assign receive_cell_avail = rx_cell_avail_i ^ state_q.cfg[MCSR_RXPOL_BIT];
  assign transmit_cell_avail = tx_cell_avail_i ^ state_q.cfg[MCSR_TXPOL_BIT];
  assign path_rdi_o = state_q.cfg[MCSR_APRDI_BIT] &&
                      (los_i || lof_i || line_ais_i || lop_i || path_ais_i);
  assign line_rdi_o = state_q.cfg[MCSR_ALRDI_BIT] && (los_i || lof_i || line_ais_i);
  assign line_febe_o = state_q.lfebe;
  assign path_febe_o = state_q.pfebe;
  // delineation flag reaches the pin only when enabled
  assign irq_out_n = !((|(block_irq_i & 8'hbf)) ||
                       (state_q.cell_delin_irq && cell_delin_irq_enable));
endmodule
`default_nettype wire

// *** mcsr_top_asserts.sv ***
// checker for the master register bank ports
// assumes one sys_clk domain; bound to mcsr_top below
`timescale 1ns/10ps
`default_nettype none
module mcsr_top_asserts (
  input wire logic sys_clk, // clock
  input wire logic arst_n, // reset
  input wire logic clk_en, // enable
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_ack_o, // answer
  input wire logic rx_cell_avail_i, // raw avail
  input wire logic receive_cell_avail, // avail out
  input wire logic los_i, // alarm
  input wire logic lof_i, // alarm
  input wire logic line_ais_i, // alarm
  input wire logic line_rdi_o, // rdi out
  input wire logic line_bip_err_i, // bip event
  input wire logic line_febe_o, // febe out
  input wire logic [7:0] block_irq_i, // requests
  input wire logic irq_out_n, // interrupt
  input wire logic meter_load_o, // load pulse
  input wire logic fp_i, // pin in
  input wire logic fp_oe, // pin enable
  input wire logic fp_align_o, // align out
  input wire logic [1:0] line_rate_o // rate
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // bus answer: exactly one ack, one cycle late
  sequence taken_s; wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en; endsequence
  sequence pulse_s; wb_ack_o ##1 !wb_ack_o; endsequence
  a_bus_answer: assert property (taken_s |=> pulse_s)
    else $error("ack not a single pulse");
  // polarity may only move when a write lands
  a_rx_polarity: assert property (!wb_ack_o |-> $stable(rx_cell_avail_i ^ receive_cell_avail))
    else $error("rx avail polarity moved");
  a_line_rdi: assert property (!(los_i || lof_i || line_ais_i) |-> !line_rdi_o)
    else $error("line rdi without alarm");
  a_febe_cause: assert property (line_febe_o |-> $past(line_bip_err_i))
    else $error("febe without bip error");
  a_irq_low: assert property ((block_irq_i & 8'hbf) != 8'h00 |-> !irq_out_n)
    else $error("interrupt not driven");
  a_meter_pulse: assert property (meter_load_o |=> !meter_load_o)
    else $error("meter load too long");
  a_fp_input: assert property (!fp_oe |-> fp_align_o == fp_i)
    else $error("frame pulse not passed in");
  a_rate_legal: assert property (line_rate_o[1])
    else $error("reserved rate code");
endmodule
bind mcsr_top mcsr_top_asserts mcsr_top_asserts_inst (.sys_clk, .arst_n, .clk_en, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .rx_cell_avail_i, .receive_cell_avail, .los_i, .lof_i, .line_ais_i,
  .line_rdi_o, .line_bip_err_i, .line_febe_o, .block_irq_i, .irq_out_n, .meter_load_o,
  .fp_i, .fp_oe, .fp_align_o, .line_rate_o);
`default_nettype wire

// *** mcsr_host.sv ***
// host processor model: classic wishbone master
// assumes a slave that always answers; the bench bounds any hang
`timescale 1ns/10ps
`default_nettype none
module mcsr_host (
  input wire logic clk, // system clock
  input wire logic ack, // slave answer
  output logic cyc, // cycle and strobe
  output logic we, // write enable
  output logic [9:0] adr, // byte address
  output logic [31:0] dat // write data
);
  initial begin
    cyc = 1'b0;
    we = 1'b0;
    adr = 10'h000;
    dat = 32'h00000000;
  end
  // ==========================================
  // one cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, d};
    do @(posedge clk); while (ack !== 1'b1);
    // released lines never keep the old value
    cyc <= 1'b0;
    we <= ~we;
    adr <= ~adr;
    dat <= ~dat;
  endtask
endmodule
`default_nettype wire

// *** mcsr_top_tb.sv ***
// self-checking bench for the master register bank
// assumes mcsr_host drives the bus and the checker is bound
`timescale 1ns/10ps
`default_nettype none
module mcsr_top_tb;
  import mcsr_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, wb_cyc_i, wb_we_i, wb_ack_o;
  logic meter_busy_i = 1'b0, fp_i = 1'b0, tx_frame_pulse_i = 1'b0, rx_cell_avail_i = 1'b0;
  logic tx_cell_avail_i = 1'b0, los_i = 1'b0, lof_i = 1'b0, line_ais_i = 1'b0, lop_i = 1'b0;
  logic path_ais_i = 1'b0, line_bip_err_i = 1'b0, path_bip_err_i = 1'b0, lcd_state_i = 1'b0;
  logic cell_delin_irq_enable = 1'b0, soft_reset_o, meter_load_o, fp_o, fp_oe, fp_align_o;
  logic receive_cell_avail, transmit_cell_avail, path_rdi_o, line_rdi_o, line_febe_o;
  logic path_febe_o, irq_out_n;
  logic [9:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0] block_irq_i = 8'h00;
  logic [4:0] mon_clk_i = 5'h00;
  logic [1:0] line_rate_o;
  logic [3:0] wb_sel_i = 4'hf;
  int miscompares = 0, total_checks = 0, seed = 32'h7045, cycles = 0;
  logic [31:0] exp_q[$], msk_q[$];
  mcsr_top mcsr_top_inst (.sys_clk, .arst_n, .clk_en, .wb_cyc_i, .wb_stb_i(wb_cyc_i),
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .soft_reset_o,
    .meter_load_o, .meter_busy_i, .fp_i, .fp_o, .fp_oe, .tx_frame_pulse_i, .fp_align_o,
    .rx_cell_avail_i, .receive_cell_avail, .tx_cell_avail_i, .transmit_cell_avail, .los_i,
    .lof_i, .line_ais_i, .lop_i, .path_ais_i, .path_rdi_o, .line_rdi_o, .line_bip_err_i,
    .path_bip_err_i, .line_febe_o, .path_febe_o, .block_irq_i, .lcd_state_i,
    .cell_delin_irq_enable, .mon_clk_i, .line_rate_o, .irq_out_n);
  mcsr_host mcsr_host_inst (.clk(sys_clk), .ack(wb_ack_o), .cyc(wb_cyc_i), .we(wb_we_i),
    .adr(wb_adr_i), .dat(wb_dat_i));
  initial forever #10 sys_clk = ~sys_clk;
  // ==========================================
  // helpers
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: pin %b want %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    mcsr_host_inst.xfer(1'b1, idx, d);
  endtask
  // note the expected read, the watcher compares it
  task automatic rd(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    mcsr_host_inst.xfer(1'b0, idx, 8'h00);
  endtask
  // read watcher and hang limit
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 5000) begin
      miscompares++;
      give_verdict();
    end
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      total_checks++;
      if ((wb_dat_o & msk_q.pop_front()) !== exp_q.pop_front()) begin
        miscompares++;
        $display("unexpected at %0t: read data %h", $time, wb_dat_o);
      end
    end
  end
  // ==========================================
  // main sequence
  initial begin
    logic [7:0] c;
    logic [4:0] al;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(MCSR_IDX_CFG, 32'h7f, 32'h71);
    rd(MCSR_IDX_RATE, 32'h03, 32'h03);
    rd(MCSR_IDX_RESET, 32'hffffffff, {25'h0, MCSR_FAMILY_CODE, 1'b0, MCSR_REVISION});
    $display("test 1 done");
    for (int i = 0; i < 4; i++) begin
      c = 8'($random(seed)) & 8'h7d;
      al = 5'($random(seed));
      wr(MCSR_IDX_CFG, c);
      {los_i, lof_i, line_ais_i, lop_i, path_ais_i} <= al;
      {rx_cell_avail_i, tx_cell_avail_i, fp_i, tx_frame_pulse_i} <= al[3:0];
      @(posedge sys_clk);
      {line_bip_err_i, path_bip_err_i} <= 2'b11;
      @(posedge sys_clk);
      {line_bip_err_i, path_bip_err_i} <= 2'b00;
      #1 chk(line_febe_o, c[6]);
      chk(path_febe_o, c[6]);
      chk(receive_cell_avail, al[3] ^ c[2]);
      chk(transmit_cell_avail, al[2] ^ c[3]);
      chk(fp_oe, !c[0]);
      chk(path_rdi_o, c[4] & (|al));
      chk(line_rdi_o, c[5] & (|al[4:2]));
      rd(MCSR_IDX_CFG, 32'h7f, {24'h0, c});
    end
    $display("test 2 done");
    meter_busy_i <= 1'b1;
    wr(MCSR_IDX_RESET, 8'h00);
    rd(MCSR_IDX_RESET, 32'h88, 32'h08);
    repeat (12) @(posedge sys_clk);
    rd(MCSR_IDX_RESET, 32'h88, 32'h08);
    meter_busy_i <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(MCSR_IDX_RESET, 32'h88, 32'h00);
    $display("test 3 done");
    wr(MCSR_IDX_RESET, 8'h80);
    #1 chk(soft_reset_o, 1'b1);
    wr(MCSR_IDX_RESET, 8'h00);
    #1 chk(soft_reset_o, 1'b0);
    wr(MCSR_IDX_RESET, 8'h80);
    arst_n <= 1'b0;
    @(posedge sys_clk);
    arst_n <= 1'b1;
    #1 chk(soft_reset_o, 1'b0);
    $display("test 4 done");
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      block_irq_i <= 8'h01 << i;
      rd(MCSR_IDX_IRQ, 32'hbf, 32'(8'h01 << i));
      #1 chk(irq_out_n, i == 6);
    end
    @(posedge sys_clk);
    {block_irq_i, cell_delin_irq_enable, lcd_state_i} <= {8'h00, 2'b11};
    repeat (3) @(posedge sys_clk);
    #1 chk(irq_out_n, 1'b0);
    rd(MCSR_IDX_IRQ, 32'h40, 32'h40);
    rd(MCSR_IDX_IRQ, 32'h40, 32'h00);
    {cell_delin_irq_enable, lcd_state_i} <= 2'b00;
    repeat (3) @(posedge sys_clk);
    #1 chk(irq_out_n, 1'b1);
    rd(MCSR_IDX_IRQ, 32'h40, 32'h40);
    $display("test 5 done");
    rd(MCSR_IDX_CLK, 32'h1f, 32'h00);
    for (int i = 0; i < 5; i++) begin
      mon_clk_i <= 5'h01 << i;
      @(posedge sys_clk);
      mon_clk_i <= 5'h00;
      rd(MCSR_IDX_CLK, 32'h1f, 32'(5'h01 << i));
    end
    rd(MCSR_IDX_CLK, 32'h1f, 32'h00);
    // a clock pulse that lands while the block is frozen must leave no trace
    clk_en <= 1'b0;
    mon_clk_i <= 5'h1f;
    @(posedge sys_clk);
    mon_clk_i <= 5'h00;
    clk_en <= 1'b1;
    rd(MCSR_IDX_CLK, 32'h1f, 32'h00);
    // a write without the low byte lane selected is ignored
    wb_sel_i <= 4'he;
    wr(MCSR_IDX_CFG, 8'h00);
    wb_sel_i <= 4'hf;
    rd(MCSR_IDX_CFG, 32'h7f, 32'h71);
    for (int r = 2; r < 4; r++) begin
      wr(MCSR_IDX_RATE, 8'(r));
      rd(MCSR_IDX_RATE, 32'h03, 32'(r));
    end
    wr(8'h81, 8'hff);
    rd(8'h81, 32'hffffffff, 32'h0);
    rd(MCSR_IDX_CFG, 32'h7f, 32'h71);
    $display("test 6 done");
    give_verdict();
  end
endmodule
`default_nettype wire
